// ==== rtl/mtm_modulo_timer.sv ====
// Modulo timer: 16-bit up-counter with prescaler and Avalon-MM registers.
//
// Overview of operation
// - 16-bit up-count, wraps after modulo match.
// - Overflow flag bit 7 set on wrap.
// - Flag cleared by read-while-set then write zero.
// - Counter-reset write also clears overflow flag.
// - Interrupt enable bit 6 gates irq.
// - Counter reset bit 5, write-only, reads zero.
// - Counter reset loads modulo value immediately.
// - Stop bit 4, reset-set, holds count.
// - Status bits 3..0 read zero.
// - Four selectable prescaler clock sources.
// - Nine power-of-two prescale ratios.
// - Modulo match provided as output.
// - External clock synchronised; max quarter bus.
// - Counts in wait; interrupt wakes from wait.
// - Disabled in stop; never a stop wakeup.
// - Deep stop wake or reset exit resets timer.
// - Counting suspended during background debug.
// - Clock source encoding 00/01/10/11, reset 00.
// - Prescale codes above 8 divide by 256.
// - Changing source or prescale keeps count.
// - Counter bytes read coherently through latch.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module mtm_modulo_timer #(
  parameter int CNT_W = 16 // Counter width.
) (
  input wire logic ref_clk, // System bus clock, 100 MHz.
  input wire logic rst, // Synchronous active-high reset.
  input wire logic [mtm_pkg::ADDR_W-1:0] avs_address, // Word index.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall.
  input wire logic fixed_freq_clock, // Fixed-frequency clock pin.
  input wire logic external_count_clock, // External count clock pin.
  input wire mtm_pkg::mtm_mode_t mode, // Power and debug modes.
  output logic irq, // Overflow interrupt request.
  output logic wake_req, // Wake from wait mode.
  output logic match // Modulo compare match.
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mod_r;
  logic [CNT_W-1:0] mod_buf_r;
  logic [CNT_W-1:0] latch_r;
  logic latch_hold_r;
  logic ovf_r;
  logic ovf_armed_r;
  logic ien_r;
  logic stp_r;
  mtm_pkg::mtm_clk_cfg_t cfg_r;
  logic [8:0] pre_r;
  logic ack_r;
  logic [2:0] fix_sync_r;
  logic [2:0] ext_sync_r;
  logic src_tick;
  logic pre_tick;
  logic tick;
  logic wr_sc;
  logic trst;
  logic rd_sc;
  logic rd_cnt;
  logic soft_rst;
  logic run;

  // Clip prescale codes above the maximum to divide by 256.
  function automatic logic [3:0] ps_eff(input logic [3:0] ps);
    ps_eff = (ps > mtm_pkg::PS_MAX) ? mtm_pkg::PS_MAX : ps;
  endfunction : ps_eff

  function automatic logic hit(input logic [mtm_pkg::ADDR_W-1:0] a,
                               input logic [mtm_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  // One-cycle wait state: every access is answered on the second edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  wire acc_w = avs_write & ack_r & avs_byteenable[0];
  wire acc_r = avs_read & ack_r;
  assign wr_sc = acc_w & hit(avs_address, mtm_pkg::IDX_SC);
  assign trst = wr_sc & avs_writedata[mtm_pkg::SC_RST];
  assign rd_sc = acc_r & hit(avs_address, mtm_pkg::IDX_SC);
  // The latch is taken in the cycle that also loads the read data, so
  // the byte handed back and the held other half come from one count.
  assign rd_cnt = avs_read & ~ack_r &
                  (hit(avs_address, mtm_pkg::IDX_COUNT_HIGH_BYTE) |
                   hit(avs_address, mtm_pkg::IDX_COUNT_LOW_BYTE));
  // Deep-stop wake and reset exit from shallow stop restore reset state.
  assign soft_rst = mode.deep_wake | mode.stop_rst_exit;
  // Stop modes freeze the timer; debug suspends it; wait lets it run.
  assign run = ~stp_r & ~mode.stop_mode & ~mode.debug_mode;

  // Pins pass two flops first; the third flop feeds edge detection.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fix_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
    end else begin
      fix_sync_r <= {fix_sync_r[1:0], fixed_freq_clock};
      ext_sync_r <= {ext_sync_r[1:0], external_count_clock};
    end
  end

  always_comb begin
    case (cfg_r.src)
      mtm_pkg::SRC_BUS: src_tick = 1'b1;
      mtm_pkg::SRC_FIX: src_tick = fix_sync_r[1] & ~fix_sync_r[2];
      mtm_pkg::SRC_EXT_FALL: src_tick = ~ext_sync_r[1] & ext_sync_r[2];
      mtm_pkg::SRC_EXT_RISE: src_tick = ext_sync_r[1] & ~ext_sync_r[2];
      default: src_tick = 1'b0;
    endcase
  end

  // Free-running prescaler; a source or ratio change never clears count.
  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst | trst) begin
      pre_r <= 9'h000;
    end else if (src_tick & run) begin
      pre_r <= pre_r + 9'h001;
    end
  end

  // Tick when the low bits roll over: divide by 2^ps.
  wire [8:0] pre_mask =
    9'(({1'b0, 8'hFF} >> (mtm_pkg::PS_MAX - ps_eff(cfg_r.ps))));
  assign pre_tick = ((pre_r & pre_mask) == pre_mask);
  assign tick = src_tick & run & pre_tick;

  // Modulo zero behaves as all ones: full-range free run.
  assign match = (mod_r == '0) ? (cnt_r == '1) : (cnt_r == mod_r);

  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst) begin
      cnt_r <= mtm_pkg::CNT_RST;
    end else if (trst) begin
      cnt_r <= mtm_pkg::CNT_RST;
    end else if (tick) begin
      cnt_r <= match ? '0 : cnt_r + 1'b1;
    end
  end

  // Modulo writes land in a buffer, applied on overflow or counter reset.
  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst) begin
      mod_buf_r <= mtm_pkg::MOD_RST;
      mod_r <= mtm_pkg::MOD_RST;
    end else begin
      if (acc_w & hit(avs_address, mtm_pkg::IDX_MODULO_HIGH_BYTE)) begin
        mod_buf_r[15:8] <= avs_writedata[7:0];
      end
      if (acc_w & hit(avs_address, mtm_pkg::IDX_MODULO_LOW_BYTE)) begin
        mod_buf_r[7:0] <= avs_writedata[7:0];
      end
      if (trst) begin
        mod_r <= mod_buf_r;
      end else if (tick & match) begin
        mod_r <= mod_buf_r;
      end
    end
  end

  // Overflow flag: set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst) begin
      ovf_r <= 1'b0;
      ovf_armed_r <= 1'b0;
    end else begin
      if (tick & match) begin
        ovf_r <= 1'b1;
      end else if (trst) begin
        ovf_r <= 1'b0;
      end else if (wr_sc & ovf_armed_r & ~avs_writedata[mtm_pkg::SC_OVF]) begin
        ovf_r <= 1'b0;
      end
      if (rd_sc & ovf_r) begin
        ovf_armed_r <= 1'b1;
      end else if (wr_sc) begin
        ovf_armed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst) begin
      ien_r <= 1'b0;
      stp_r <= 1'b1;
      cfg_r <= '0;
    end else begin
      if (wr_sc) begin
        ien_r <= avs_writedata[mtm_pkg::SC_IEN];
        stp_r <= avs_writedata[mtm_pkg::SC_STP];
      end
      if (acc_w & hit(avs_address, mtm_pkg::IDX_CLK)) begin
        cfg_r.src <= avs_writedata[mtm_pkg::CLK_SRC_HI:mtm_pkg::CLK_SRC_LO];
        cfg_r.ps <= avs_writedata[mtm_pkg::CLK_PS_HI:mtm_pkg::CLK_PS_LO];
      end
    end
  end

  // Coherent counter read; the latch is frozen while debug is active.
  always_ff @(posedge ref_clk) begin
    if (rst | soft_rst | trst) begin
      latch_hold_r <= 1'b0;
      latch_r <= '0;
    end else if (rd_cnt & ~mode.debug_mode) begin
      if (!latch_hold_r) begin
        latch_r <= cnt_r;
      end
      latch_hold_r <= ~latch_hold_r;
    end
  end

  wire [CNT_W-1:0] cnt_view =
    (latch_hold_r & ~mode.debug_mode) ? latch_r : cnt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        mtm_pkg::IDX_SC: avs_readdata <= {24'h000000, ovf_r, ien_r, 1'b0,
                                          stp_r, 4'h0};
        mtm_pkg::IDX_CLK: avs_readdata <= {24'h000000, 2'h0, cfg_r.src,
                                           cfg_r.ps};
        mtm_pkg::IDX_COUNT_HIGH_BYTE: avs_readdata <= {24'h000000, cnt_view[15:8]};
        mtm_pkg::IDX_COUNT_LOW_BYTE: avs_readdata <= {24'h000000, cnt_view[7:0]};
        mtm_pkg::IDX_MODULO_HIGH_BYTE: avs_readdata <= {24'h000000, mod_buf_r[15:8]};
        mtm_pkg::IDX_MODULO_LOW_BYTE: avs_readdata <= {24'h000000, mod_buf_r[7:0]};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign irq = ien_r & ovf_r;
  assign wake_req = irq & mode.wait_mode & ~mode.stop_mode;

  // Steps shared by the checks below.
  sequence s_wrap;
    tick && match && !soft_rst;
  endsequence

  sequence s_count_zero;
    cnt_r == '0;
  endsequence

  sequence s_quiet;
    !trst && !soft_rst;
  endsequence

  a_wrap_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (s_wrap)
    |=> s_count_zero)
    else $error("counter did not wrap to zero");

  a_ovf_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (ovf_r && !wr_sc && s_quiet)
    |=> ovf_r)
    else $error("overflow flag dropped");

  a_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_sc && ovf_armed_r && !avs_writedata[mtm_pkg::SC_OVF] &&
     !(tick && match) && !soft_rst)
    |=> !ovf_r)
    else $error("armed clear did not clear flag");

  a_one_no_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_sc && avs_writedata[mtm_pkg::SC_OVF] && ovf_r && s_quiet)
    |=> ovf_r)
    else $error("writing one cleared flag");

  // No disable here: the values left by reset itself are checked.
  a_reset_state: assert property (@(posedge ref_clk)
    rst
    |=> (!ien_r && stp_r && cfg_r == '0))
    else $error("control bits wrong after reset");

  a_cfg_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_w && hit(avs_address, mtm_pkg::IDX_CLK) && !tick && s_quiet)
    |=> $stable(cnt_r))
    else $error("clock setting change moved count");

  a_bus_source: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_r.src == mtm_pkg::SRC_BUS)
    |-> src_tick)
    else $error("bus source gave no tick");

  a_ps_clip: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_r.ps > mtm_pkg::PS_MAX)
    |-> (pre_mask == 9'h0FF))
    else $error("large prescale code not clipped");

  a_match_out: assert property (@(posedge ref_clk) disable iff (rst)
    (mod_r != '0 && cnt_r == mod_r)
    |-> match)
    else $error("match output missing");

  a_free_run: assert property (@(posedge ref_clk) disable iff (rst)
    (mod_r == '0 && cnt_r != '1)
    |-> !match)
    else $error("early match in free run");

  a_mod_defer: assert property (@(posedge ref_clk) disable iff (rst)
    (!(tick && match) && s_quiet)
    |=> $stable(mod_r))
    else $error("modulo applied early");

  a_wait_wake: assert property (@(posedge ref_clk) disable iff (rst)
    (irq && mode.wait_mode && !mode.stop_mode)
    |-> wake_req)
    else $error("no wake from wait");

  a_soft_reset: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst
    |=> (s_count_zero and (!ovf_r && stp_r)))
    else $error("mode exit did not reset timer");

  a_latch_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    (mode.debug_mode && s_quiet)
    |=> ($stable(latch_hold_r) && $stable(latch_r)))
    else $error("read latch moved in debug");

  // Every request sees exactly one wait state before it is answered.
  a_one_wait: assert property (@(posedge ref_clk) disable iff (rst)
    ((avs_read || avs_write) && !ack_r)
    |-> avs_waitrequest)
    else $error("request answered without wait");

  a_answer_next: assert property (@(posedge ref_clk) disable iff (rst)
    ((avs_read || avs_write) && !ack_r)
    |=> !avs_waitrequest)
    else $error("answer did not follow wait");

  a_ovf_on_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && match && !soft_rst) |=> (ovf_r && cnt_r == '0))
    else $error("overflow flag not set on wrap");
  a_trst_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (trst && !(tick && match) && !soft_rst) |=> (!ovf_r && cnt_r == '0))
    else $error("counter reset did not clear");
  a_stop_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (stp_r && !trst && !soft_rst) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  a_debug_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (mode.debug_mode && !trst && !soft_rst) |=> $stable(cnt_r))
    else $error("counter moved in debug");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq == (ien_r && ovf_r))
    else $error("interrupt mismatch");
  a_no_stop_wake: assert property (@(posedge ref_clk) disable iff (rst)
    mode.stop_mode |-> !wake_req)
    else $error("wake in stop");
  a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && !match && !trst && !soft_rst) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("count did not step");
  a_mod_apply: assert property (@(posedge ref_clk) disable iff (rst)
    (trst && !soft_rst) |=> mod_r == $past(mod_buf_r))
    else $error("modulo not applied");
  a_sc_reads: assert property (@(posedge ref_clk) disable iff (rst)
    (avs_read && !ack_r && avs_address == mtm_pkg::IDX_SC) |=>
    (avs_readdata[5] == 1'b0 && avs_readdata[3:0] == 4'h0))
    else $error("reserved bits nonzero");
endmodule : mtm_modulo_timer

// ==== inc/mtm_pkg.sv ====
// Package for the modulo timer: register map, fields and types.
package mtm_pkg;
  localparam int ADDR_W = 3;
  // Word offsets (byte address = 4 * index).
  localparam logic [ADDR_W-1:0] IDX_SC = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_CLK = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_COUNT_HIGH_BYTE = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_COUNT_LOW_BYTE = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_MODULO_HIGH_BYTE = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_MODULO_LOW_BYTE = 3'h5;
  localparam int SC_OVF = 7;
  localparam int SC_IEN = 6;
  localparam int SC_RST = 5;
  localparam int SC_STP = 4;
  localparam int CLK_SRC_HI = 5;
  localparam int CLK_SRC_LO = 4;
  localparam int CLK_PS_HI = 3;
  localparam int CLK_PS_LO = 0;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_FIX = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL = 2'h2;
  localparam logic [1:0] SRC_EXT_RISE = 2'h3;
  typedef struct packed {
    logic [1:0] src;
    logic [3:0] ps;
  } mtm_clk_cfg_t;
  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic deep_wake;
    logic stop_rst_exit;
    logic debug_mode;
  } mtm_mode_t;
endpackage : mtm_pkg

// ==== test/tb_mtm_modulo_timer.sv ====
// Self-checking bench for the modulo timer block.
`timescale 1ns/100ps
module tb_mtm_modulo_timer;
  localparam logic [2:0] SC = mtm_pkg::IDX_SC;
  localparam logic [2:0] CK = mtm_pkg::IDX_CLK;
  localparam logic [2:0] ML = mtm_pkg::IDX_MODULO_LOW_BYTE;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [mtm_pkg::ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] div = 4'h0;
  mtm_pkg::mtm_mode_t mode = '0;
  logic irq;
  logic wake;
  logic match;
  logic [7:0] rv;
  int mismatches = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  // Pin clocks stay well below a quarter of the bus rate.
  always @(posedge ref_clk) div <= div + 4'h1;
  mtm_modulo_timer dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1),
    .avs_readdata(rdata), .avs_waitrequest(wreq),
    .fixed_freq_clock(div[2]), .external_count_clock(div[3]),
    .mode(mode), .irq(irq), .wake_req(wake), .match(match)
  );
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo();
    chk(16'h0000, 16'h0001);
    report_and_stop();
  endtask : tmo
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0) tmo();
    rv = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd_cnt(output logic [15:0] c);
    bus(1'b0, mtm_pkg::IDX_COUNT_HIGH_BYTE, 8'h00);
    c[15:8] = rv;
    bus(1'b0, mtm_pkg::IDX_COUNT_LOW_BYTE, 8'h00);
    c[7:0] = rv;
  endtask : rd_cnt
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      bus(1'b0, SC, 8'h00);
      n++;
    end while (rv[7] !== 1'b1 && n < 20);
    if (rv[7] !== 1'b1) tmo();
  endtask : wait_flag
  task automatic match_rise(output int n);
    n = 0;
    while (match === 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    while (match !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (match !== 1'b1) tmo();
  endtask : match_rise
  task automatic run_cfg(input logic [7:0] ck, input logic [7:0] ml);
    bus(1'b1, mtm_pkg::IDX_MODULO_HIGH_BYTE, 8'h00);
    bus(1'b1, ML, ml);
    bus(1'b1, CK, ck);
    bus(1'b1, SC, 8'h20);
  endtask : run_cfg
  task automatic t_reset();
    bus(1'b0, SC, 8'h00);
    chk(rv, 8'h10);
    bus(1'b0, CK, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, mtm_pkg::IDX_COUNT_LOW_BYTE, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, ML, 8'h00);
    chk(rv, 8'h00);
    bus(1'b0, 3'h6, 8'h00);
    chk({rv, irq}, 9'h000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rates();
    int n;
    logic [7:0] cf [9] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h0F,
                           8'h10, 8'h20, 8'h30};
    logic [15:0] ex [9] = '{16'h0004, 16'h0008, 16'h0020, 16'h0200,
                            16'h0400, 16'h0400, 16'h0020, 16'h0040,
                            16'h0040};
    for (int i = 0; i < 9; i++) begin
      run_cfg(cf[i], 8'h03);
      match_rise(n);
      match_rise(n);
      chk(16'(n), ex[i]);
    end
    $display("t_rates done");
  endtask : t_rates
  task automatic t_flag();
    logic [15:0] c;
    run_cfg(8'h00, 8'h03);
    wait_flag();
    bus(1'b1, SC, 8'h90);
    bus(1'b0, SC, 8'h00);
    chk(rv, 8'h90);
    bus(1'b1, SC, 8'h10);
    bus(1'b0, SC, 8'h00);
    chk(rv, 8'h10);
    bus(1'b1, SC, 8'h40);
    wait_flag();
    bus(1'b1, SC, 8'hD0);
    chk(irq, 1'b1);
    mode.wait_mode <= 1'b1;
    @(posedge ref_clk);
    chk(wake, 1'b1);
    mode.stop_mode <= 1'b1;
    @(posedge ref_clk);
    chk(wake, 1'b0);
    mode <= '0;
    bus(1'b1, SC, 8'h30);
    chk(irq, 1'b0);
    bus(1'b0, SC, 8'h00);
    chk(rv, 8'h10);
    rd_cnt(c);
    chk(c, 16'h0000);
    $display("t_flag done");
  endtask : t_flag
  task automatic freeze(input logic [4:0] m, output logic [15:0] d);
    logic [15:0] c0;
    logic [15:0] c1;
    mode <= m;
    @(posedge ref_clk);
    rd_cnt(c0);
    repeat (20) @(posedge ref_clk);
    rd_cnt(c1);
    mode <= '0;
    d = c1 - c0;
  endtask : freeze
  task automatic t_run();
    logic [15:0] d;
    run_cfg(8'h00, 8'h00);
    freeze(5'h10, d);
    chk(d, 16'h001A);
    freeze(5'h08, d);
    chk(d, 16'h0000);
    freeze(5'h01, d);
    chk(d, 16'h0000);
    $display("t_run done");
  endtask : t_run
  task automatic t_wake();
    logic [15:0] c;
    for (int i = 0; i < 2; i++) begin
      mode <= (i == 0) ? 5'h04 : 5'h02;
      @(posedge ref_clk);
      mode <= '0;
      @(posedge ref_clk);
      bus(1'b0, SC, 8'h00);
      chk(rv, 8'h10);
      rd_cnt(c);
      chk(c, 16'h0000);
    end
    $display("t_wake done");
  endtask : t_wake
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_rates();
    t_flag();
    t_run();
    t_wake();
    report_and_stop();
  end
endmodule : tb_mtm_modulo_timer
